/* File: tb/dee_ctrl_checker.sv */
// Port-level assertions for the data EEPROM write control block.
// Bound to every dee_ctrl instance; sees only its top ports.
`timescale 1ns/1ps
module dee_ctrl_checker #(
  parameter int PUT_TICKS = 3,
  parameter int WRITE_TICKS = 2
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic WRITE_DONE_IRQ,
  input wire logic WRITE_BUSY
);
  localparam int TC = dee_pkg::TICK_CYCLES;
  logic xfer;
  logic wr_ok;
  logic mapped;
  logic [1:0] code;
  logic [1:0] h1, h2, h3;
  logic start_q, flag_q;
  int pcnt, bcnt;
  assign xfer = PSEL & PENABLE;
  assign wr_ok = xfer & PWRITE;
  assign mapped = PADDR inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
  assign code = !(wr_ok && PADDR == dee_pkg::OFS_UNLOCK) ? 2'h0 :
    PWDATA[7:0] == dee_pkg::KEY_FIRST ? 2'h1 :
    PWDATA[7:0] == dee_pkg::KEY_SECOND ? 2'h2 : 2'h0;
  // Last three completed transfers, newest in h1
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      {h1, h2, h3, start_q, flag_q} <= 8'h00;
      pcnt <= 0;
      bcnt <= 0;
    end else begin
      if (xfer) {h1, h2, h3} <= {code, h1, h2};
      start_q <= wr_ok && PADDR == dee_pkg::OFS_CTRL && PWDATA[dee_pkg::CTRL_WR];
      flag_q <= wr_ok && PADDR == dee_pkg::OFS_FLAG;
      if (pcnt < PUT_TICKS * TC) pcnt <= pcnt + 1;
      bcnt <= WRITE_BUSY ? bcnt + 1 : 0;
    end
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  sequence s_unlocked;
    h2 == 2'h2 && h3 == 2'h1;
  endsequence
  sequence s_busy_run;
    WRITE_BUSY [*8];
  endsequence
  AST_BUSY_CAUSE: assert property ($rose(WRITE_BUSY) |-> start_q)
    else $error("busy rose without a write start");
  AST_BUSY_SEQ: assert property ($rose(WRITE_BUSY) |-> s_unlocked)
    else $error("busy rose without consecutive unlock keys");
  AST_PUT_BLOCK: assert property (pcnt < (PUT_TICKS - 1) * TC |-> !$rose(WRITE_BUSY))
    else $error("write started during power-up block");
  AST_BUSY_MIN: assert property ($fell(WRITE_BUSY) |-> bcnt >= (WRITE_TICKS - 1) * TC)
    else $error("write cycle ended early");
  AST_BUSY_MAX: assert property (bcnt <= (WRITE_TICKS + 1) * TC)
    else $error("write cycle did not end");
  AST_BUSY_HOLD: assert property ($rose(WRITE_BUSY) |-> s_busy_run)
    else $error("busy dropped right after start");
  AST_IRQ_HOLD: assert property ($fell(WRITE_DONE_IRQ) |-> flag_q)
    else $error("done interrupt dropped without flag write");
  AST_IRQ_CAUSE: assert property ($rose(WRITE_DONE_IRQ) |-> $fell(WRITE_BUSY) || flag_q)
    else $error("done interrupt rose without completion");
  AST_SLVERR: assert property (PSLVERR == (xfer && !mapped))
    else $error("slave error mismatch");
  AST_READY: assert property (PREADY)
    else $error("ready low");
endmodule : dee_ctrl_checker

bind dee_ctrl dee_ctrl_checker #(.PUT_TICKS(PUT_TICKS), .WRITE_TICKS(WRITE_TICKS)) chk_u (
  .MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .WRITE_DONE_IRQ(WRITE_DONE_IRQ), .WRITE_BUSY(WRITE_BUSY));

/* File: tb/tb_data_eeprom_write_control.sv */
// Testbench for dee_ctrl: unlock, write, read and refusal over APB.
// Expects package, design and checker compiled first.
`timescale 1ns/1ps
module tb_data_eeprom_write_control;
  logic MCLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, CODE_PROT = 0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA, rdv;
  logic PREADY, PSLVERR, WRITE_DONE_IRQ, WRITE_BUSY, err;
  int n_errors = 0, samples_checked = 0, cyc = 0;
  dee_ctrl #(.PUT_TICKS(3), .WRITE_TICKS(2)) dut_u (.MCLK(MCLK), .RST(RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .CODE_PROT(CODE_PROT),
    .WRITE_DONE_IRQ(WRITE_DONE_IRQ), .WRITE_BUSY(WRITE_BUSY));
  initial forever #2 MCLK = ~MCLK;
  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge MCLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do @(posedge MCLK); while (PREADY !== 1'b1);
    rdv = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rdv);
  endtask : rd
  task automatic seq(input logic [7:0] k1, input logic [7:0] k2, input logic [31:0] c);
    // Back-to-back with nothing in between, so the sequence is not disturbed
    wr(dee_pkg::OFS_UNLOCK, {24'h0, k1});
    wr(dee_pkg::OFS_UNLOCK, {24'h0, k2});
    wr(dee_pkg::OFS_CTRL, c);
  endtask : seq
  initial begin
    repeat (5) @(posedge MCLK);
    RST <= 1'b0;
    rd(dee_pkg::OFS_CTRL, 32'h08, "ctrl reset");
    wr(dee_pkg::OFS_CTRL, 32'h04);
    seq(8'h55, 8'hAA, 32'h06);
    rd(dee_pkg::OFS_CTRL, 32'h0C, "ctrl power-up");
    do apb(1'b0, dee_pkg::OFS_CTRL, 32'h0); while (rdv[dee_pkg::CTRL_PUT_BUSY] !== 1'b0);
    $display("test power-up done");
    wr(dee_pkg::OFS_FLAG, 32'h02);
    wr(dee_pkg::OFS_ADDR, 32'h05);
    wr(dee_pkg::OFS_DATA, 32'hA5);
    wr(dee_pkg::OFS_CTRL, 32'h00);
    seq(8'h55, 8'hAA, 32'h06);
    rd(dee_pkg::OFS_CTRL, 32'h04, "ctrl no permit");
    seq(8'hAA, 8'h55, 32'h06);
    rd(dee_pkg::OFS_CTRL, 32'h04, "ctrl bad order");
    wr(dee_pkg::OFS_UNLOCK, 32'h55);
    rd(dee_pkg::OFS_DATA, 32'hA5, "data gap");
    wr(dee_pkg::OFS_UNLOCK, 32'hAA);
    wr(dee_pkg::OFS_CTRL, 32'h06);
    rd(dee_pkg::OFS_CTRL, 32'h04, "ctrl gap");
    $display("test unlock done");
    seq(8'h55, 8'hAA, 32'h06);
    rd(dee_pkg::OFS_CTRL, 32'h06, "ctrl started");
    chk("busy set", 32'h1, {31'h0, WRITE_BUSY});
    wr(dee_pkg::OFS_DATA, 32'h3C);
    wr(dee_pkg::OFS_CTRL, 32'h00);
    // Permit back on, so only the busy gate can refuse the next unlock
    wr(dee_pkg::OFS_CTRL, 32'h04);
    seq(8'h55, 8'hAA, 32'h06);
    rd(dee_pkg::OFS_CTRL, 32'h06, "ctrl busy");
    while (WRITE_BUSY !== 1'b0) @(posedge MCLK);
    rd(dee_pkg::OFS_CTRL, 32'h04, "ctrl done");
    chk("irq set", 32'h1, {31'h0, WRITE_DONE_IRQ});
    rd(dee_pkg::OFS_FLAG, 32'h03, "flag set");
    rd(dee_pkg::OFS_FLAG, 32'h03, "flag held");
    wr(dee_pkg::OFS_FLAG, 32'h03);
    rd(dee_pkg::OFS_FLAG, 32'h02, "flag clear");
    chk("irq clear", 32'h0, {31'h0, WRITE_DONE_IRQ});
    wr(dee_pkg::OFS_CTRL, 32'h05);
    rd(dee_pkg::OFS_DATA, 32'hA5, "read back");
    $display("test write done");
    CODE_PROT <= 1'b1;
    wr(dee_pkg::OFS_ADDR, 32'h06);
    wr(dee_pkg::OFS_DATA, 32'h5A);
    seq(8'h55, 8'hAA, 32'h06);
    // Busy is only visible one edge after the start transfer
    rd(dee_pkg::OFS_CTRL, 32'h16, "protected busy");
    while (WRITE_BUSY !== 1'b0) @(posedge MCLK);
    wr(dee_pkg::OFS_CTRL, 32'h05);
    rd(dee_pkg::OFS_DATA, 32'h5A, "protected data");
    rd(dee_pkg::OFS_CTRL, 32'h14, "protected ctrl");
    $display("test protect done");
    apb(1'b1, 8'h20, 32'hFF);
    chk("unmapped write error", 32'h1, {31'h0, err});
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped read error", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rdv);
    rd(dee_pkg::OFS_UNLOCK, 32'h0, "unlock read");
    $display("test refusal done");
    print_verdict();
  end
endmodule : tb_data_eeprom_write_control

/* File: verilog/dee_ctrl.sv */
// Data EEPROM write control: APB register file, unlock sequencer, write timer,
// power-up write block and read path into the cell array.
// Assumes APB3 master on MCLK; CODE_PROT arrives asynchronously from fuse logic.
`timescale 1ns/1ps
module dee_ctrl #(
  parameter int AW = 7,
  parameter int PUT_TICKS = dee_pkg::PUT_TICKS,
  parameter int WRITE_TICKS = dee_pkg::WRITE_TICKS
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic CODE_PROT,
  output logic WRITE_DONE_IRQ,
  output logic WRITE_BUSY
);

  localparam int DIVW = $clog2(dee_pkg::TICK_CYCLES + 1);
  localparam int PUTW = $clog2(PUT_TICKS + 1);
  localparam int WRW = $clog2(WRITE_TICKS + 1);
  localparam logic [DIVW-1:0] DIV_LAST = DIVW'(dee_pkg::TICK_CYCLES - 1);
  localparam logic [PUTW-1:0] PUT_LAST = PUTW'(PUT_TICKS - 1);
  localparam logic [WRW-1:0] WR_LAST = WRW'(WRITE_TICKS - 1);

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [7:0] data;
    logic rd_pend;
    logic wr_bit;
    logic permit;
    logic done_flag;
    logic irq_en;
    dee_pkg::dee_seq_e seq;
    logic [DIVW-1:0] div;
    logic [PUTW-1:0] put_cnt;
    logic put_busy;
    logic [WRW-1:0] wr_cnt;
    logic [AW-1:0] wr_addr;
    logic [7:0] wr_data;
    logic [2:0] cp_sync;
    logic code_prot;
    logic [31:0] prdata;
  } dee_state_s;

  dee_state_s st_reg;
  dee_state_s st_next;

  logic acc;
  logic setup;
  logic mapped;
  logic tick;
  logic wr_finish;
  logic rd_start;
  logic [7:0] mem_rdata;
  logic [7:0] data_view;
  logic [31:0] rd_word;

  // Known register offsets
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == dee_pkg::OFS_ADDR) || (a == dee_pkg::OFS_DATA) ||
                (a == dee_pkg::OFS_CTRL) || (a == dee_pkg::OFS_UNLOCK) ||
                (a == dee_pkg::OFS_FLAG);
  endfunction : is_mapped

  // Write to a given offset in the access phase
  function automatic logic wr_hit(input logic a_acc, input logic a_wr,
                                  input logic [7:0] a, input logic [7:0] ofs);
    wr_hit = a_acc && a_wr && (a == ofs);
  endfunction : wr_hit

  assign acc = PSEL && PENABLE;
  assign setup = PSEL && !PENABLE;
  assign mapped = is_mapped(PADDR);
  assign PREADY = 1'b1;
  assign PSLVERR = acc && !mapped;
  assign PRDATA = st_reg.prdata;
  assign WRITE_BUSY = st_reg.wr_bit;
  assign WRITE_DONE_IRQ = st_reg.done_flag && st_reg.irq_en;

  assign tick = (st_reg.div == DIV_LAST);
  assign wr_finish = st_reg.wr_bit && tick && (st_reg.wr_cnt == WR_LAST);
  assign rd_start = wr_hit(acc, PWRITE, PADDR, dee_pkg::OFS_CTRL) &&
                    PWDATA[dee_pkg::CTRL_RD];

  // Fresh read data is visible before it lands in the register
  assign data_view = st_reg.rd_pend ? mem_rdata : st_reg.data;

  always_comb begin
    rd_word = 32'h0000_0000;
    case (PADDR)
      dee_pkg::OFS_ADDR: rd_word[AW-1:0] = st_reg.addr;
      dee_pkg::OFS_DATA: rd_word[7:0] = data_view;
      dee_pkg::OFS_CTRL: begin
        rd_word[dee_pkg::CTRL_RD] = st_reg.rd_pend;
        rd_word[dee_pkg::CTRL_WR] = st_reg.wr_bit;
        rd_word[dee_pkg::CTRL_PERMIT] = st_reg.permit;
        rd_word[dee_pkg::CTRL_PUT_BUSY] = st_reg.put_busy;
        rd_word[dee_pkg::CTRL_CODE_PROT] = st_reg.code_prot;
      end
      dee_pkg::OFS_FLAG: begin
        rd_word[dee_pkg::FLAG_DONE] = st_reg.done_flag;
        rd_word[dee_pkg::FLAG_IRQ_EN] = st_reg.irq_en;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_comb begin
    st_next = st_reg;

    // Microsecond time base
    st_next.div = tick ? '0 : DIVW'(st_reg.div + 1'b1);

    // Power-up write block
    if (st_reg.put_busy && tick) begin
      if (st_reg.put_cnt == PUT_LAST) begin
        st_next.put_busy = 1'b0;
      end else begin
        st_next.put_cnt = PUTW'(st_reg.put_cnt + 1'b1);
      end
    end

    // Code protect level, counted once two stages agree
    st_next.cp_sync = {st_reg.cp_sync[1:0], CODE_PROT};
    if (st_reg.cp_sync[1] == st_reg.cp_sync[2]) begin
      st_next.code_prot = st_reg.cp_sync[2];
    end

    // Read capture during setup phase
    if (setup) begin
      st_next.prdata = rd_word;
    end

    // Land read data in the data register
    if (st_reg.rd_pend) begin
      st_next.data = mem_rdata;
      st_next.rd_pend = 1'b0;
    end

    // Software register writes
    if (wr_hit(acc, PWRITE, PADDR, dee_pkg::OFS_ADDR)) begin
      st_next.addr = PWDATA[AW-1:0];
    end
    if (wr_hit(acc, PWRITE, PADDR, dee_pkg::OFS_DATA)) begin
      st_next.data = PWDATA[7:0];
    end
    if (wr_hit(acc, PWRITE, PADDR, dee_pkg::OFS_CTRL)) begin
      st_next.permit = PWDATA[dee_pkg::CTRL_PERMIT];
    end
    if (rd_start) begin
      st_next.rd_pend = 1'b1;
    end
    if (wr_hit(acc, PWRITE, PADDR, dee_pkg::OFS_FLAG)) begin
      st_next.irq_en = PWDATA[dee_pkg::FLAG_IRQ_EN];
      if (PWDATA[dee_pkg::FLAG_DONE]) begin
        st_next.done_flag = 1'b0;
      end
    end

    // Unlock sequencer: one step per completed bus transfer
    if (acc) begin
      case (st_reg.seq)
        dee_pkg::SEQ_IDLE: begin
          if (!st_reg.wr_bit &&
              wr_hit(acc, PWRITE, PADDR, dee_pkg::OFS_UNLOCK) &&
              PWDATA[7:0] == dee_pkg::KEY_FIRST) begin
            st_next.seq = dee_pkg::SEQ_GOT_FIRST;
          end
        end
        dee_pkg::SEQ_GOT_FIRST: begin
          if (wr_hit(acc, PWRITE, PADDR, dee_pkg::OFS_UNLOCK) &&
              PWDATA[7:0] == dee_pkg::KEY_SECOND) begin
            st_next.seq = dee_pkg::SEQ_ARMED;
          end else begin
            st_next.seq = dee_pkg::SEQ_IDLE;
          end
        end
        dee_pkg::SEQ_ARMED: begin
          st_next.seq = dee_pkg::SEQ_IDLE;
          if (wr_hit(acc, PWRITE, PADDR, dee_pkg::OFS_CTRL) &&
              PWDATA[dee_pkg::CTRL_WR] &&
              st_reg.permit &&
              !st_reg.put_busy) begin
            st_next.wr_bit = 1'b1;
            st_next.wr_cnt = '0;
            st_next.wr_addr = st_reg.addr;
            st_next.wr_data = st_reg.data;
          end
        end
        default: st_next.seq = dee_pkg::SEQ_IDLE;
      endcase
    end

    // Write timer runs on regardless of the permit bit
    if (st_reg.wr_bit && tick) begin
      if (wr_finish) begin
        st_next.wr_bit = 1'b0;
      end else begin
        st_next.wr_cnt = WRW'(st_reg.wr_cnt + 1'b1);
      end
    end

    // Completion set wins over a same-cycle clear
    if (wr_finish) begin
      st_next.done_flag = 1'b1;
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      st_reg.addr <= '0;
      st_reg.data <= dee_pkg::DATA_RESET;
      st_reg.rd_pend <= 1'b0;
      st_reg.wr_bit <= 1'b0;
      st_reg.permit <= 1'b0;
      st_reg.done_flag <= 1'b0;
      st_reg.irq_en <= 1'b0;
      st_reg.seq <= dee_pkg::SEQ_IDLE;
      st_reg.div <= '0;
      st_reg.put_cnt <= '0;
      st_reg.put_busy <= 1'b1;
      st_reg.wr_cnt <= '0;
      st_reg.wr_addr <= '0;
      st_reg.wr_data <= '0;
      st_reg.cp_sync <= '0;
      st_reg.code_prot <= 1'b0;
      st_reg.prdata <= 32'h0000_0000;
    end else begin
      st_reg <= st_next;
    end
  end

  // Cell array carries plain data in every protection state
  dee_mem #(
    .AW(AW),
    .DW(8)
  ) u_mem (
    .clk(MCLK),
    .rst(RST),
    .we(wr_finish),
    .waddr(st_reg.wr_addr),
    .wdata(st_reg.wr_data),
    .re(rd_start),
    .raddr(st_reg.addr),
    .rdata(mem_rdata)
  );

endmodule : dee_ctrl

/* File: verilog/dee_mem.sv */
// Byte-wide data EEPROM cell array with one write and one registered read port.
// Assumes writes and reads come from the control block on the same clock.
`timescale 1ns/1ps
module dee_mem #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);

  logic [DW-1:0] cells [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      cells[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else if (re) begin
      rdata <= cells[raddr];
    end
  end

endmodule : dee_mem

/* File: verilog/dee_pkg.sv */
// Constants, register map and enums for the data EEPROM write control block.
// Assumes an APB3 master with 32-bit data and a 250 MHz MCLK.
//
// Behaviour
// - A byte write starts only after 55h then AAh to unlock, then write start.
// - The three steps must be consecutive bus transfers, else the write is dropped.
// - Write start is refused unless the write permit bit was already set.
// - Hardware never clears the write permit bit; only software writes and reset change it.
// - A started write completes even if software clears the permit bit meanwhile.
// - On completion hardware clears write start and sets the write done flag.
// - The write done flag stays set until software clears it.
// - The write done flag drives an interrupt output that software can enable.
// - Reset clears the write permit bit.
// - Writes are blocked while the 72 ms power-up timer runs.
// - Under code protection data is still read and written unscrambled.
// - After a read start the addressed byte is in the data register next cycle.
// - The data register holds its byte until a new read or a software write.
package dee_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_ADDR = 8'h00;
  localparam logic [7:0] OFS_DATA = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_UNLOCK = 8'h0C;
  localparam logic [7:0] OFS_FLAG = 8'h10;

  // Control register fields
  localparam int CTRL_RD = 0;
  localparam int CTRL_WR = 1;
  localparam int CTRL_PERMIT = 2;
  localparam int CTRL_PUT_BUSY = 3;
  localparam int CTRL_CODE_PROT = 4;

  // Flag register fields
  localparam int FLAG_DONE = 0;
  localparam int FLAG_IRQ_EN = 1;

  // Unlock keys
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;

  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PUT_MS = 72;
  localparam int PUT_TICKS = PUT_MS * (1000000 / TICK_NS);
  localparam int WRITE_TICKS = 4;

  // Reset values
  localparam logic [7:0] DATA_RESET = 8'h00;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_GOT_FIRST = 2'b01,
    SEQ_ARMED = 2'b10
  } dee_seq_e;

endpackage : dee_pkg
